// *** hw/eep_slave.sv ***
// Behaviour
// - Start is SDA fall with SCL high, stop is SDA rise; both detected.
// - SDA changes only while SCL low, except for start and stop.
// - Bits sampled on SCL rise; output bits shifted after SCL fall.
// - SDA is driven only low; released for a one.
// - Eight-bit words, MSB first; ack low on ninth clock after received word.
// - Standby at power-up and after stop once internal work finishes.
// - Device address word follows start; bits 3..1 must match select straps.
// - Address LSB high starts read, low starts write.
// - Match gives ack; mismatch gives no ack, standby until next start.
// - Protect pin high: no location altered; low: normal operation.
// - 256 pages of 32 bytes, 13-bit word address.
// - Byte write: device, word address, one data byte, each acked, stop.
// - Stop after write starts programming up to 5 ms; no response meanwhile.
// - Page write: up to 31 more bytes, each acked, ended by stop.
// - Write increments only low five address bits, wrapping inside page.
// - Over 32 data bytes wrap in page, later bytes replace earlier.
// - Polling: address acked only after programming finishes, then continues.
// - Address counter holds last address plus one between operations.
// - Read counter wraps from last byte of array to first.
// - Current read sends byte at counter; controller nacks then stops.
// - Controller ack gives next byte; nack and stop end read.
`timescale 1ns/1ps
`default_nettype none

module eep_slave
    import eep_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYC_DFLT
)
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       scl,
    input  wire logic       sda_i,
    input  wire logic       wp,
    input  wire logic [2:0] chip_select_straps,
    output var  logic       sda_o,
    output var  logic       sda_oe,
    output var  logic       write_busy
);

    localparam int unsigned CNT_W = $clog2(PROG_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_PAGE  = CNT_W'(PAGE_BYTES);
    localparam logic [CNT_W-1:0] CNT_START = CNT_W'(PROG_CYCLES);
    localparam logic [COL_W-1:0] COL_ONE   = COL_W'(1);
    localparam logic [ADDR_W-1:0] ADR_ONE  = ADDR_W'(1);

    // ****************************************************************
    // Address arithmetic
    // ****************************************************************
    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
        page_inc = {a[ADDR_W-1:COL_W], a[COL_W-1:0] + COL_ONE};
    endfunction : page_inc

    function automatic logic [ADDR_W-1:0] array_inc(input logic [ADDR_W-1:0] a);
        array_inc = a + ADR_ONE;
    endfunction : array_inc

    // ****************************************************************
    // Link domain: bit capture on the controller's clock
    // ****************************************************************
    // Held stable until the next SCL rise, long after the sys side
    // has seen the filtered edge, so it crosses without its own sync.
    logic rx_bit;

    always_ff @(posedge scl)
    begin
        rx_bit <= sda_i;
    end

    // ****************************************************************
    // Pin synchronisers and glitch filter
    // ****************************************************************
    eep_pins_t pin_raw;
    eep_pins_t sync1;
    eep_pins_t sync2;
    eep_pins_t sync3;
    eep_pins_t filt;
    eep_pins_t filt_q;
    eep_pins_t next_filt;

    assign pin_raw   = {chip_select_straps, wp, sda_i, scl};
    // A level counts only once stages two and three agree
    assign next_filt = (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sync1  <= PINS_IDLE;
            sync2  <= PINS_IDLE;
            sync3  <= PINS_IDLE;
            filt   <= PINS_IDLE;
            filt_q <= PINS_IDLE;
        end
        else
        begin
            sync1  <= pin_raw;
            sync2  <= sync1;
            sync3  <= sync2;
            filt   <= next_filt;
            filt_q <= filt;
        end
    end

    // ****************************************************************
    // Bus events
    // ****************************************************************
    wire logic rise_ev  = filt.scl & ~filt_q.scl;
    wire logic fall_ev  = ~filt.scl & filt_q.scl;
    wire logic start_ev = filt.scl & filt_q.scl & filt_q.sda & ~filt.sda;
    wire logic stop_ev  = filt.scl & filt_q.scl & ~filt_q.sda & filt.sda;

    // ****************************************************************
    // Protocol state
    // ****************************************************************
    eep_state_t        st;
    eep_state_t        next_st;
    logic [3:0]        bitn;
    logic [3:0]        next_bitn;
    logic [7:0]        sh;
    logic [7:0]        next_sh;
    logic [7:0]        obyte;
    logic [7:0]        next_obyte;
    logic              ack_want;
    logic              next_ack;
    logic              next_oe;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [HI_W-1:0]   addr_hi;
    logic [HI_W-1:0]   next_hi;
    logic [CNT_W-1:0]  prog_cnt;
    logic [CNT_W-1:0]  next_cnt;

    logic [7:0]            mem [2**ADDR_W];
    logic [7:0]            pg_data [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pg_valid;
    logic [ROW_W-1:0]      pg_row;

    wire logic [7:0]       rx_byte = {sh[6:0], rx_bit};
    wire logic [7:0]       mem_q   = mem[addr];
    wire logic             busy    = prog_cnt != '0;
    wire logic             dev_hit = (rx_byte[7:4] == DEV_TYPE)
                                   & (rx_byte[3:1] == filt.straps)
                                   & ~busy;
    wire logic             frame_byte = rise_ev & (bitn == BIT_LAST) & (st != S_IDLE);
    wire logic             data_byte  = frame_byte & (st == S_WDAT);
    wire logic             prog_start = stop_ev & (st == S_WDAT) & (|pg_valid)
                                      & ~filt.wp & ~busy;
    wire logic             commit  = busy & (prog_cnt <= CNT_PAGE);
    wire logic [COL_W-1:0] cidx    = COL_W'(prog_cnt - CNT_ONE);
    wire logic             rd_ackbit = rise_ev & (bitn == BIT_ACK) & (st == S_RD) & ~ack_want;

    always_comb
    begin
        next_st    = st;
        next_bitn  = bitn;
        next_sh    = sh;
        next_obyte = obyte;
        next_ack   = ack_want;
        next_oe    = sda_oe;
        next_addr  = addr;
        next_hi    = addr_hi;
        if (start_ev)
        begin
            next_st   = S_DEV;
            next_bitn = '0;
            next_oe   = 1'b0;
        end
        else if (stop_ev)
        begin
            next_st = S_IDLE;
            next_oe = 1'b0;
        end
        else if (rise_ev && st != S_IDLE)
        begin
            next_bitn = bitn + BIT_ONE;
            if (bitn < BIT_ACK)
            begin
                next_sh = rx_byte;
            end
            if (bitn == BIT_LAST)
            begin
                next_ack = 1'b1;
                case (st)
                    S_DEV:
                    begin
                        if (dev_hit)
                        begin
                            next_st = rx_byte[0] ? S_RD : S_WHI;
                        end
                        else
                        begin
                            next_st  = S_IDLE;
                            next_ack = 1'b0;
                        end
                    end
                    S_WHI:
                    begin
                        next_hi = rx_byte[HI_W-1:0];
                        next_st = S_WLO;
                    end
                    S_WLO:
                    begin
                        next_addr = {addr_hi, rx_byte};
                        next_st   = S_WDAT;
                    end
                    S_WDAT:
                    begin
                        next_addr = page_inc(addr);
                    end
                    S_RD:
                    begin
                        next_ack = 1'b0;
                    end
                    default:
                    begin
                        next_st = S_IDLE;
                    end
                endcase
            end
            if (rd_ackbit)
            begin
                next_addr = array_inc(addr);
                if (rx_bit)
                begin
                    next_st = S_IDLE;
                end
            end
        end
        else if (fall_ev && st != S_IDLE)
        begin
            if (bitn == BIT_ACK)
            begin
                next_oe = ack_want;
            end
            else if (bitn == BIT_END)
            begin
                next_bitn = '0;
                next_oe   = 1'b0;
                if (st == S_RD)
                begin
                    next_obyte = mem_q;
                    next_oe    = ~mem_q[7];
                end
            end
            else if (st == S_RD && bitn != '0)
            begin
                next_oe = ~obyte[3'(BIT_LAST - bitn)];
            end
        end
    end

    always_comb
    begin
        next_cnt = prog_cnt;
        if (prog_start)
        begin
            next_cnt = CNT_START;
        end
        else if (busy)
        begin
            next_cnt = prog_cnt - CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            st         <= S_IDLE;
            bitn       <= '0;
            sh         <= '0;
            obyte      <= '0;
            ack_want   <= 1'b0;
            sda_oe     <= 1'b0;
            sda_o      <= 1'b0;
            addr       <= '0;
            addr_hi    <= '0;
            prog_cnt   <= '0;
            write_busy <= 1'b0;
        end
        else
        begin
            st         <= next_st;
            bitn       <= next_bitn;
            sh         <= next_sh;
            obyte      <= next_obyte;
            ack_want   <= next_ack;
            sda_oe     <= next_oe;
            sda_o      <= 1'b0;
            addr       <= next_addr;
            addr_hi    <= next_hi;
            prog_cnt   <= next_cnt;
            write_busy <= next_cnt != '0;
        end
    end

    // ****************************************************************
    // Page buffer and array programming
    // ****************************************************************
    // Bytes are staged and only reach the array after the closing stop,
    // so a write cut short by a new start leaves the array untouched.
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            pg_valid <= '0;
            pg_row   <= '0;
        end
        else if (frame_byte && st == S_WLO)
        begin
            pg_valid <= '0;
        end
        else if (data_byte)
        begin
            pg_valid[addr[COL_W-1:0]] <= 1'b1;
            pg_row                    <= addr[ADDR_W-1:COL_W];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (data_byte)
        begin
            pg_data[addr[COL_W-1:0]] <= rx_byte;
        end
    end

    // One byte per cycle in the last page-length cycles of the busy window
    always_ff @(posedge sys_clk)
    begin
        if (commit && pg_valid[cidx])
        begin
            mem[{pg_row, cidx}] <= pg_data[cidx];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_oe_after_edge: assert property (@(posedge sys_clk) disable iff (srst)
        $changed(sda_oe) |-> $past(fall_ev) || $past(start_ev) || $past(stop_ev))
        else $error("SDA drive changed while SCL high");

    a_drive_low_only: assert property (@(posedge sys_clk) disable iff (srst)
        sda_oe |-> sda_o == 1'b0)
        else $error("SDA driven high");

    a_ack_ninth: assert property (@(posedge sys_clk) disable iff (srst)
        (fall_ev && st != S_IDLE && bitn == BIT_ACK && ack_want && !start_ev && !stop_ev)
        |=> sda_oe)
        else $error("Ack not driven on ninth clock");

    a_dev_mismatch: assert property (@(posedge sys_clk) disable iff (srst)
        (frame_byte && st == S_DEV && rx_byte[3:1] != filt.straps && !start_ev && !stop_ev)
        |=> st == S_IDLE && !ack_want)
        else $error("Wrong strap value accepted");

    a_busy_no_ack: assert property (@(posedge sys_clk) disable iff (srst)
        (frame_byte && st == S_DEV && busy && !start_ev && !stop_ev) |=> !ack_want)
        else $error("Ack given while programming");

    a_read_dir: assert property (@(posedge sys_clk) disable iff (srst)
        (frame_byte && st == S_DEV && dev_hit && rx_byte[0] && !start_ev && !stop_ev)
        |=> st == S_RD)
        else $error("Read direction not taken");

    a_page_wrap: assert property (@(posedge sys_clk) disable iff (srst)
        (data_byte && !start_ev && !stop_ev)
        |=> addr == {$past(addr[ADDR_W-1:COL_W]), $past(addr[COL_W-1:0]) + COL_ONE})
        else $error("Write address left the page");

    a_read_step: assert property (@(posedge sys_clk) disable iff (srst)
        (rd_ackbit && !start_ev && !stop_ev) |=> addr == $past(addr) + ADR_ONE)
        else $error("Read address did not advance");

    a_protect_hold: assert property (@(posedge sys_clk) disable iff (srst)
        (stop_ev && filt.wp && !busy) |=> !busy [*2])
        else $error("Program cycle under write protect");

    a_prog_length: assert property (@(posedge sys_clk) disable iff (srst)
        prog_start |=> prog_cnt == CNT_START ##1 write_busy)
        else $error("Program window length wrong");

    a_stop_standby: assert property (@(posedge sys_clk) disable iff (srst)
        (stop_ev && !start_ev) |=> st == S_IDLE && !sda_oe)
        else $error("Stop did not return to standby");

    c_page_write: cover property (@(posedge sys_clk) disable iff (srst) prog_start);
    c_seq_read: cover property (@(posedge sys_clk) disable iff (srst) rd_ackbit && !rx_bit);
    c_poll_nack: cover property (@(posedge sys_clk) disable iff (srst)
        frame_byte && st == S_DEV && busy);

endmodule : eep_slave

`default_nettype wire

// *** hw/eep_pkg.sv ***
package eep_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned SYS_MHZ       = 40;
    // Longest self-timed programming time, in microseconds
    localparam int unsigned T_PROG_US     = 5000;
    localparam int unsigned PROG_CYC_DFLT = T_PROG_US * SYS_MHZ;

    // ****************************************************************
    // Array organisation
    // ****************************************************************
    localparam int unsigned ADDR_W     = 13;
    localparam int unsigned COL_W      = 5;
    localparam int unsigned ROW_W      = ADDR_W - COL_W;
    localparam int unsigned PAGE_BYTES = 32;
    localparam int unsigned HI_W       = ADDR_W - 8;

    // ****************************************************************
    // Frame layout and address word
    // ****************************************************************
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;
    localparam logic [3:0] BIT_END  = 4'h9;
    localparam logic [3:0] BIT_ONE  = 4'h1;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DEV  = 3'b001,
        S_WHI  = 3'b010,
        S_WLO  = 3'b011,
        S_WDAT = 3'b100,
        S_RD   = 3'b101
    } eep_state_t;

    typedef struct packed {
        logic [2:0] straps;
        logic       wp;
        logic       sda;
        logic       scl;
    } eep_pins_t;

    // Idle bus: both lines high, straps and protect low
    localparam eep_pins_t PINS_IDLE = 6'h03;

endpackage : eep_pkg

// *** sim/eep_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module eep_ctrl_model
(
    input  wire logic sys_clk,
    input  wire logic link_clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);

    // ****************************************************************
    // Bus idles with both lines released
    // ****************************************************************
    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // Quarter bit on the link clock, then aligned to the system falling edge
    task q();
        repeat (42) @(posedge link_clk);
        @(negedge sys_clk);
    endtask : q

    // ****************************************************************
    // Bit, start and stop
    // ****************************************************************
    // Data moves 500 ns into the low phase, well clear of the output delay
    task bitx(input logic tx, output logic rx);
        q();
        sda_low = ~tx;
        q();
        scl = 1'b1;
        q();
        q();
        rx  = sda;
        scl = 1'b0;
    endtask : bitx

    task start();
        if (scl == 1'b0)
        begin
            q();
            sda_low = 1'b0;
            q();
            scl = 1'b1;
            q();
        end
        sda_low = 1'b1;
        q();
        scl = 1'b0;
    endtask : start

    task stop();
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask : stop

    // ****************************************************************
    // Words
    // ****************************************************************
    task wr(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(b[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask : wr

    // More high: acknowledge and ask for the next byte
    task rd(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(1'b1, b[i]);
        end
        bitx(~more, r);
    endtask : rd

    // Nine released clocks, each must see the line high
    task recover(output logic ok);
        logic r;
        ok = 1'b1;
        repeat (9)
        begin
            bitx(1'b1, r);
            ok = ok & r;
        end
    endtask : recover

endmodule : eep_ctrl_model

`default_nettype wire

// *** sim/eep_slave_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module eep_slave_tb;
    import eep_pkg::*;

    localparam int unsigned PROG   = 2000;
    localparam logic [2:0]  STRAPS = 3'h5;

    logic       sys_clk, link_clk, srst, wp, scl, sda_low, sda_o, sda_oe, write_busy;
    logic       ack, ok;
    logic [7:0] b;
    logic [7:0] page_exp [32];
    wire  logic sda_w;
    int         error_cnt, check_count, n;

    // Device side only pulls low when enabled and its data bit is low
    assign sda_w = ~((sda_oe & ~sda_o) | sda_low);

    eep_slave #(.PROG_CYCLES(PROG)) eep_slave_i (.sys_clk(sys_clk), .srst(srst), .scl(scl),
        .sda_i(sda_w), .wp(wp), .chip_select_straps(STRAPS), .sda_o(sda_o),
        .sda_oe(sda_oe), .write_busy(write_busy));

    eep_ctrl_model ctrl_i (.sys_clk(sys_clk), .link_clk(link_clk), .sda(sda_w),
        .scl(scl), .sda_low(sda_low));

    // ****************************************************************
    // Clocks and watchdog
    // ****************************************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        link_clk = 1'b0;
        #3.7;
        forever #6 link_clk = ~link_clk;
    end

    initial
    begin
        // A clean run needs roughly 80k cycles
        repeat (95000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task conclude();
        if (error_cnt == 0 && check_count > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task hdr(input logic rd, input logic [2:0] sel);
        ctrl_i.start();
        ctrl_i.wr({DEV_TYPE, sel, rd}, ack);
    endtask : hdr

    // Word address phase, repeated start, read header
    task goto_read(input logic [12:0] a);
        ctrl_i.wr({3'h0, a[12:8]}, ack);
        chk("addr hi ack", {7'h0, ack}, 8'h01);
        ctrl_i.wr(a[7:0], ack);
        chk("addr lo ack", {7'h0, ack}, 8'h01);
        hdr(1'b1, STRAPS);
        chk("read hdr ack", {7'h0, ack}, 8'h01);
    endtask : goto_read

    // Writes a header until acknowledged; programming must cause refusals
    task poll();
        n   = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && n < 20)
        begin
            hdr(1'b0, STRAPS);
            if (ack !== 1'b1)
            begin
                n++;
            end
        end
        chk("poll refused", {7'h0, n > 0}, 8'h01);
        chk("poll ack", {7'h0, ack}, 8'h01);
        chk("busy at ack", {7'h0, write_busy}, 8'h00);
    endtask : poll

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_mismatch();
        hdr(1'b0, STRAPS ^ 3'h1);
        chk("wrong straps", {7'h0, ack}, 8'h00);
        ctrl_i.wr({DEV_TYPE, STRAPS, 1'b0}, ack);
        chk("no start", {7'h0, ack}, 8'h00);
        hdr(1'b0, STRAPS);
        ctrl_i.start();
        ctrl_i.wr({4'hB, STRAPS, 1'b0}, ack);
        chk("wrong type", {7'h0, ack}, 8'h00);
        hdr(1'b0, STRAPS);
        chk("good header", {7'h0, ack}, 8'h01);
        ctrl_i.stop();
    endtask : t_mismatch

    task t_byte_write();
        hdr(1'b0, STRAPS);
        ctrl_i.wr(8'h00, ack);
        ctrl_i.wr(8'h00, ack);
        ctrl_i.wr(8'hC3, ack);
        chk("data ack", {7'h0, ack}, 8'h01);
        ctrl_i.stop();
        chk("busy after stop", {7'h0, write_busy}, 8'h01);
        poll();
        goto_read(13'h0000);
        ctrl_i.rd(1'b0, b);
        chk("byte readback", b, 8'hC3);
        ctrl_i.stop();
    endtask : t_byte_write

    // 34 bytes from column 30 of the last page: wrap and overwrite
    task t_page_write();
        hdr(1'b0, STRAPS);
        ctrl_i.wr(8'h1F, ack);
        ctrl_i.wr(8'hFE, ack);
        for (int i = 0; i < 34; i++)
        begin
            page_exp[(30 + i) % 32] = 8'h40 + 8'(i);
            ctrl_i.wr(8'h40 + 8'(i), ack);
            chk("page ack", {7'h0, ack}, 8'h01);
        end
        ctrl_i.stop();
        chk("busy page", {7'h0, write_busy}, 8'h01);
        poll();
        goto_read(13'h1FE0);
        for (int i = 0; i < 32; i++)
        begin
            ctrl_i.rd(i < 31, b);
            chk("page byte", b, page_exp[i]);
        end
        ctrl_i.stop();
        hdr(1'b1, STRAPS);
        chk("current hdr", {7'h0, ack}, 8'h01);
        ctrl_i.rd(1'b0, b);
        chk("counter wrap", b, 8'hC3);
        ctrl_i.stop();
    endtask : t_page_write

    task t_protect();
        wp = 1'b1;
        hdr(1'b0, STRAPS);
        ctrl_i.wr(8'h00, ack);
        ctrl_i.wr(8'h00, ack);
        ctrl_i.wr(8'h11, ack);
        chk("wp data ack", {7'h0, ack}, 8'h01);
        ctrl_i.stop();
        repeat (10) @(negedge sys_clk);
        chk("wp no busy", {7'h0, write_busy}, 8'h00);
        wp = 1'b0;
        hdr(1'b0, STRAPS);
        chk("wp idle ack", {7'h0, ack}, 8'h01);
        goto_read(13'h0000);
        ctrl_i.rd(1'b0, b);
        chk("wp unchanged", b, 8'hC3);
        ctrl_i.stop();
    endtask : t_protect

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        srst        = 1'b1;
        wp          = 1'b0;
        error_cnt   = 0;
        check_count = 0;
        repeat (16) @(negedge sys_clk);
        srst = 1'b0;
        repeat (8) @(negedge sys_clk);
        ctrl_i.recover(ok);
        chk("recover", {7'h0, ok}, 8'h01);
        t_mismatch();
        t_byte_write();
        t_page_write();
        t_protect();
        conclude();
    end

endmodule : eep_slave_tb

`default_nettype wire
